// ==== pkg/rmi_cfg.svh ====
// Constants for the rotate/mask/insert unit: field positions, opcodes, offsets
// Assumes big-endian bit numbering of the instruction word (bit 0 = MSB)
`ifndef RMI_CFG_SVH
`define RMI_CFG_SVH
// ==========================================================
// Instruction decode
`define RMI_OPC_DWORD 6'h1E
`define RMI_OPC_WORD 6'h16
`define RMI_XO_CLR_RIGHT 3'h1
`define RMI_XO_INSERT 3'h3
// ==========================================================
// Register map (byte addresses)
`define RMI_ADDR_INSN 12'h000
`define RMI_ADDR_SRC_LO 12'h004
`define RMI_ADDR_SRC_HI 12'h008
`define RMI_ADDR_TGT_LO 12'h00C
`define RMI_ADDR_TGT_HI 12'h010
`define RMI_ADDR_CNT 12'h014
`define RMI_ADDR_CTRL 12'h018
`define RMI_ADDR_RES_LO 12'h01C
`define RMI_ADDR_RES_HI 12'h020
`define RMI_ADDR_STATUS 12'h024
`define RMI_ADDR_IRQ_STAT 12'h028
`define RMI_ADDR_IRQ_EN 12'h02C
`define RMI_ADDR_IRQ_CLR 12'h030
// Control bits
`define RMI_CTRL_SO_BIT 0
// Interrupt bits
`define RMI_IRQ_DONE_BIT 0
`define RMI_IRQ_ILL_BIT 1
// AXI responses
`define RMI_RESP_OKAY 2'h0
`define RMI_RESP_SLVERR 2'h2
`endif

// ==== pkg/rmi_pkg.sv ====
// Types for the rotate/mask/insert unit
// Assumes rmi_cfg.svh is on the include path
package rmi_pkg;
   // ==========================================================
   // Operation kinds
   typedef enum logic [1:0] {
      RMI_OP_NONE = 2'b00,
      RMI_OP_CLR_RIGHT = 2'b01,
      RMI_OP_INSERT = 2'b10,
      RMI_OP_WORD_INSERT = 2'b11
   } rmi_op_t;
   // Condition field zero: lt, gt, eq, so
   typedef struct packed {
      logic less_than_zero_flag;
      logic greater_than_zero_flag;
      logic zero_result_flag;
      logic summary_overflow;
   } rmi_cond_t;
   // Decoded instruction fields
   typedef struct packed {
      logic [5:0] rotate_amount;
      logic [5:0] mask_field;
      logic [4:0] mask_begin_field;
      logic [4:0] mask_end_field;
      logic record_bit;
   } rmi_fields_t;
endpackage

// ==== src/rmi_unit.sv ====
// Rotate-and-mask datapath with an AXI4-Lite register front end
// Assumes a single 100 MHz clock and a well-behaved AXI4-Lite master
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "rmi_cfg.svh"
// Function
// [RULE1] Doubleword rotate, keep bits 0..end
// [RULE2] Decode opcode 30, sub-op 1, split amount
// [RULE3] Insert mask from begin to 63-amount
// [RULE4] Insert keeps target bits where mask zero
// [RULE5] Decode opcode 30, sub-op 3
// [RULE6] Doubleword forms illegal on 32-bit build
// [RULE7] Record bit updates condition field zero
// [RULE8] Word rotate by count register bits 27-31
// [RULE9] Decode opcode 22 with field layout
// [RULE10] Word insert keeps target where mask zero
// [RULE11] Begin below end+1: ones begin..end
// [RULE12] Begin equals end+1: all ones
// [RULE13] Begin above end+1: wraparound mask
// [RULE14] Never touch exception register; record updates flags
// [RULE15] Flags compare written result with zero
// [RULE16] Word insert only in legacy variant
// [RULE17] Summary flag copied from exception register
// [RULE18] Signed compare over full result width; the word form compares only result bits 31:0 of its 64-bit result
module rmi_unit import rmi_pkg::*; #(
   parameter bit IS_64BIT = 1'b1,
   parameter bit HAS_LEGACY = 1'b1
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   output logic irq
);
   // ==========================================================
   // Register storage
   logic [31:0] insn_reg;
   logic [63:0] src_reg, tgt_reg, res_reg;
   logic [31:0] cnt_reg;
   logic so_reg;
   rmi_cond_t cond_reg;
   logic cond_upd_reg, illegal_reg;
   logic [1:0] irq_stat_reg, irq_en_reg;
   logic go_reg;
   // Bus holding
   logic aw_held_reg, w_held_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_fire;
   logic [31:0] wmask;

   // ==========================================================
   // Write channel: address and data accepted in either order
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                   {8{w_strb_reg[0]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   logic wr_known;
   always_comb begin
      case ({aw_addr_reg[11:2], 2'b00})
         `RMI_ADDR_INSN, `RMI_ADDR_SRC_LO, `RMI_ADDR_SRC_HI, `RMI_ADDR_TGT_LO,
         `RMI_ADDR_TGT_HI, `RMI_ADDR_CNT, `RMI_ADDR_CTRL, `RMI_ADDR_IRQ_EN,
         `RMI_ADDR_IRQ_CLR: wr_known = 1'b1;
         default: wr_known = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RMI_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? `RMI_RESP_OKAY : `RMI_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Operand registers; writing the instruction word launches execution
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         insn_reg <= 32'h00000000;
         src_reg <= 64'h0000000000000000;
         cnt_reg <= 32'h00000000;
         so_reg <= 1'b0;
         irq_en_reg <= 2'h0;
         go_reg <= 1'b0;
      end else begin
         go_reg <= 1'b0;
         if (wr_fire) begin
            case ({aw_addr_reg[11:2], 2'b00})
               `RMI_ADDR_INSN: begin
                  insn_reg <= (insn_reg & ~wmask) | (w_data_reg & wmask);
                  go_reg <= 1'b1;
               end
               `RMI_ADDR_SRC_LO: src_reg[31:0] <= (src_reg[31:0] & ~wmask) | (w_data_reg & wmask);
               `RMI_ADDR_SRC_HI: src_reg[63:32] <= (src_reg[63:32] & ~wmask) | (w_data_reg & wmask);
               `RMI_ADDR_CNT: cnt_reg <= (cnt_reg & ~wmask) | (w_data_reg & wmask);
               `RMI_ADDR_CTRL: if (w_strb_reg[0]) so_reg <= w_data_reg[`RMI_CTRL_SO_BIT];
               `RMI_ADDR_IRQ_EN: if (w_strb_reg[0]) irq_en_reg <= w_data_reg[1:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // Decode (instruction bit 0 is the MSB, so bit n is insn[31-n])
   rmi_op_t op;
   rmi_fields_t f;
   logic dword_legal;
   assign f.rotate_amount = {insn_reg[1], insn_reg[15:11]};     // see [RULE2]
   assign f.mask_field = insn_reg[10:5];                         // see [RULE2]
   assign f.mask_begin_field = insn_reg[10:6];                   // see [RULE9]
   assign f.mask_end_field = insn_reg[5:1];                      // see [RULE9]
   assign f.record_bit = insn_reg[0];
   assign dword_legal = IS_64BIT;                                // see [RULE6]

   always_comb begin
      op = RMI_OP_NONE;
      if (insn_reg[31:26] == `RMI_OPC_DWORD && dword_legal) begin
         if (insn_reg[4:2] == `RMI_XO_CLR_RIGHT)
            op = RMI_OP_CLR_RIGHT;                               // see [RULE2]
         else if (insn_reg[4:2] == `RMI_XO_INSERT)
            op = RMI_OP_INSERT;                                  // see [RULE5]
      end else if (insn_reg[31:26] == `RMI_OPC_WORD && HAS_LEGACY) begin
         op = RMI_OP_WORD_INSERT;                                // see [RULE16]
      end
   end

   // ==========================================================
   // Datapath; mask position 0 is the MSB of each operand
   logic [63:0] rot64, mask64, ins64;
   logic [31:0] rot32, mask32;
   logic [4:0] wamt;
   logic [63:0] result;
   logic [6:0] ins_end;

   assign rot64 = (src_reg << f.rotate_amount) | (src_reg >> (7'd64 - {1'b0, f.rotate_amount}));
   assign wamt = cnt_reg[4:0];                                   // see [RULE8]
   assign rot32 = (src_reg[31:0] << wamt) | (src_reg[31:0] >> (6'd32 - {1'b0, wamt}));
   assign ins_end = 7'd63 - {1'b0, f.rotate_amount};             // see [RULE3]

   always_comb begin
      mask64 = 64'h0000000000000000;
      ins64 = 64'h0000000000000000;
      mask32 = 32'h00000000;
      for (int i = 0; i < 64; i++) begin
         if (i <= f.mask_field)
            mask64[63 - i] = 1'b1;                               // see [RULE1]
         if (i >= f.mask_field && i <= ins_end)
            ins64[63 - i] = 1'b1;                                // see [RULE3]
      end
      for (int i = 0; i < 32; i++) begin
         if ({1'b0, f.mask_begin_field} <= {1'b0, f.mask_end_field})
            mask32[31 - i] = (i >= f.mask_begin_field) && (i <= f.mask_end_field); // see [RULE11]
         else if ({1'b0, f.mask_begin_field} == {1'b0, f.mask_end_field} + 6'd1)
            mask32[31 - i] = 1'b1;                               // see [RULE12]
         else
            mask32[31 - i] = !((i > f.mask_end_field) && (i < f.mask_begin_field)); // see [RULE13]
      end
   end

   always_comb begin
      case (op)
         RMI_OP_CLR_RIGHT: result = rot64 & mask64;              // see [RULE1]
         RMI_OP_INSERT: result = (rot64 & ins64) | (tgt_reg & ~ins64); // see [RULE4]
         RMI_OP_WORD_INSERT:
            result = {tgt_reg[63:32], (rot32 & mask32) | (tgt_reg[31:0] & ~mask32)}; // see [RULE10]
         default: result = tgt_reg;
      endcase
   end

   // Word form compares its 32-bit result, doubleword forms the full 64 bits
   logic res_neg, res_zero;
   assign res_neg = (op == RMI_OP_WORD_INSERT) ? result[31] : result[63];   // see [RULE18]
   assign res_zero = (op == RMI_OP_WORD_INSERT) ? (result[31:0] == 32'h00000000) :
                     (result == 64'h0000000000000000);           // see [RULE15]

   // ==========================================================
   // Execution: one cycle after the instruction write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tgt_reg <= 64'h0000000000000000;
         res_reg <= 64'h0000000000000000;
         cond_reg <= '0;
         cond_upd_reg <= 1'b0;
         illegal_reg <= 1'b0;
      end else if (wr_fire && {aw_addr_reg[11:2], 2'b00} == `RMI_ADDR_TGT_LO) begin
         tgt_reg[31:0] <= (tgt_reg[31:0] & ~wmask) | (w_data_reg & wmask);
      end else if (wr_fire && {aw_addr_reg[11:2], 2'b00} == `RMI_ADDR_TGT_HI) begin
         tgt_reg[63:32] <= (tgt_reg[63:32] & ~wmask) | (w_data_reg & wmask);
      end else if (go_reg) begin
         illegal_reg <= (op == RMI_OP_NONE);                     // see [RULE6]
         cond_upd_reg <= 1'b0;
         if (op != RMI_OP_NONE) begin
            tgt_reg <= result;
            res_reg <= result;
            if (f.record_bit) begin                              // see [RULE7]
               cond_upd_reg <= 1'b1;
               cond_reg.less_than_zero_flag <= res_neg;          // see [RULE15]
               cond_reg.greater_than_zero_flag <= !res_neg && !res_zero;
               cond_reg.zero_result_flag <= res_zero;
               cond_reg.summary_overflow <= so_reg;              // see [RULE17] [RULE14]
            end
         end
      end
   end

   // ==========================================================
   // Interrupts: set wins over clear
   logic [1:0] irq_set, irq_clr;
   assign irq_set = {go_reg && op == RMI_OP_NONE, go_reg && op != RMI_OP_NONE};
   assign irq_clr = (wr_fire && {aw_addr_reg[11:2], 2'b00} == `RMI_ADDR_IRQ_CLR &&
                     w_strb_reg[0]) ? w_data_reg[1:0] : 2'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq_stat_reg <= 2'h0;
      else
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
   end
   assign irq = |(irq_stat_reg & irq_en_reg);

   // ==========================================================
   // Read channel
   logic [31:0] rd_val;
   logic rd_known;
   assign s_axi_arready = !s_axi_rvalid;
   always_comb begin
      rd_known = 1'b1;
      case ({s_axi_araddr[11:2], 2'b00})
         `RMI_ADDR_INSN: rd_val = insn_reg;
         `RMI_ADDR_SRC_LO: rd_val = src_reg[31:0];
         `RMI_ADDR_SRC_HI: rd_val = src_reg[63:32];
         `RMI_ADDR_TGT_LO: rd_val = tgt_reg[31:0];
         `RMI_ADDR_TGT_HI: rd_val = tgt_reg[63:32];
         `RMI_ADDR_CNT: rd_val = cnt_reg;
         `RMI_ADDR_CTRL: rd_val = {31'h0, so_reg};
         `RMI_ADDR_RES_LO: rd_val = res_reg[31:0];
         `RMI_ADDR_RES_HI: rd_val = res_reg[63:32];
         `RMI_ADDR_STATUS: rd_val = {26'h0, illegal_reg, cond_upd_reg, cond_reg};
         `RMI_ADDR_IRQ_STAT: rd_val = {30'h0, irq_stat_reg};
         `RMI_ADDR_IRQ_EN: rd_val = {30'h0, irq_en_reg};
         default: begin
            rd_val = 32'h00000000;
            rd_known = 1'b0;
         end
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RMI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_known ? `RMI_RESP_OKAY : `RMI_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   property p_clr_right;
      @(posedge aclk) disable iff (!aresetn)
      (go_reg && op == RMI_OP_CLR_RIGHT) |=> (tgt_reg == ($past(rot64) & $past(mask64)));
   endproperty
   a_clr_right: assert property (p_clr_right) else $error("clear-right wrong"); // see [RULE1]

   property p_insert_keep;
      @(posedge aclk) disable iff (!aresetn)
      (go_reg && op == RMI_OP_INSERT) |=>
         ((tgt_reg & ~$past(ins64)) == ($past(tgt_reg) & ~$past(ins64)));
   endproperty
   a_insert_keep: assert property (p_insert_keep) else $error("kept bits changed"); // see [RULE4]

   property p_word_keep;
      @(posedge aclk) disable iff (!aresetn)
      (go_reg && op == RMI_OP_WORD_INSERT) |=> ((tgt_reg[31:0] & ~$past(mask32)) ==
         ($past(tgt_reg[31:0]) & ~$past(mask32)));
   endproperty
   a_word_keep: assert property (p_word_keep) else $error("word kept bits lost"); // see [RULE10]

   property p_full_mask;
      @(posedge aclk) disable iff (!aresetn)
      ({1'b0, f.mask_begin_field} == {1'b0, f.mask_end_field} + 6'd1) |-> (mask32 == 32'hFFFFFFFF);
   endproperty
   a_full_mask: assert property (p_full_mask) else $error("full mask wrong"); // see [RULE12]

   property p_no_record;
      @(posedge aclk) disable iff (!aresetn)
      (go_reg && !f.record_bit) |=> $stable(cond_reg);
   endproperty
   a_no_record: assert property (p_no_record) else $error("unrecorded flag change"); // see [RULE7]

   property p_illegal32;
      @(posedge aclk) disable iff (!aresetn)
      (go_reg && (op == RMI_OP_NONE || (!IS_64BIT && insn_reg[31:26] == `RMI_OPC_DWORD)))
         |=> (illegal_reg && irq_stat_reg[1]);
   endproperty
   a_illegal32: assert property (p_illegal32) else $error("illegal path not taken"); // see [RULE6]

   property p_so_copy;
      @(posedge aclk) disable iff (!aresetn)
      (go_reg && op != RMI_OP_NONE && f.record_bit) |=> (cond_reg.summary_overflow == $past(so_reg)
         && $stable(so_reg));
   endproperty
   a_so_copy: assert property (p_so_copy) else $error("summary flag not copied"); // see [RULE17]

   property p_flags;
      @(posedge aclk) disable iff (!aresetn)
      (go_reg && op == RMI_OP_CLR_RIGHT && f.record_bit) |=>
         (cond_reg.zero_result_flag == (tgt_reg == 64'h0) &&
          cond_reg.less_than_zero_flag == tgt_reg[63]);
   endproperty
   a_flags: assert property (p_flags) else $error("condition flags mismatch"); // see [RULE15]
endmodule // rmi_unit

// ==== tb/rmi_axi_host.sv ====
// AXI4-Lite master model standing in for the issue side of the unit
// Assumes one clock; every output changes by NBA right after a rising edge
`timescale 1ns/100ps
module rmi_axi_host (
   // Clock
   input wire logic aclk,
   // Write channels
   output logic [11:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [11:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // ==========================================================
   // Idle levels
   initial begin
      awaddr = 12'h000;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hF;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 12'h000;
      arvalid = 1'b0;
      rready = 1'b0;
   end
   // ==========================================================
   // Bus cycles
   // Readies are looked at on the falling edge: they are combinational
   // from the slave's flops, so at the rising edge they would race.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic pa;
      logic pw;
      logic ta;
      logic tw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ta = pa && awready;
         tw = pw && wready;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      bready <= 1'b1;
      do @(negedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask
endmodule // rmi_axi_host

// ==== tb/rotate_mask_insert_unit_test.sv ====
// Self-checking bench for the rotate/mask/insert unit
// Assumes rmi_axi_host and rmi_unit are compiled first, rmi_cfg.svh on the path
`timescale 1ns/100ps
`include "rmi_cfg.svh"
module rotate_mask_insert_unit_test;
   // ==========================================================
   // Wires and bookkeeping
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [3:0] cond_exp = 4'h0;
   logic so_val = 1'b0;
   localparam logic [31:0] HI_KEEP = 32'hA5A5A5A5;
   logic [31:0] w_src [5] = '{32'h90003000, 32'hB0043000, 32'h12345678, 32'h0F0F0F0F, 32'h0};
   logic [31:0] w_cnt [5] = '{32'hFFFFFFE2, 32'h2, 32'h1F, 32'h0, 32'h7};
   logic [31:0] w_tgt [5] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'hAAAAAAAA, 32'h0000FFFF};
   int w_mb [5] = '{0, 0, 20, 6, 16};
   int w_me [5] = '{29, 29, 5, 5, 31};
   logic w_rc [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   always #5 aclk = ~aclk;
   rmi_unit dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq));
   rmi_axi_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   // ==========================================================
   // Reference arithmetic, big-endian bit numbering
   function automatic logic [63:0] msk(input int b, input int e, input int w);
      logic [63:0] m;
      m = 64'h0;
      for (int i = 0; i < w; i++)
         if ((b <= e) ? (i >= b && i <= e) : (i >= b || i <= e)) m[w-1-i] = 1'b1;
      return m;
   endfunction
   function automatic logic [63:0] rot64(input logic [63:0] x, input int n);
      return (x << n) | (x >> (64 - n));
   endfunction
   function automatic logic [31:0] rot32(input logic [31:0] x, input int n);
      return (x << n) | (x >> (32 - n));
   endfunction
   function automatic logic [3:0] flg(input logic [63:0] v, input int w);
      logic neg;
      logic zero;
      neg = (w == 32) ? v[31] : v[63];
      zero = (w == 32) ? (v[31:0] == 32'h0) : (v == 64'h0);
      return {neg, !neg && !zero, zero, so_val};
   endfunction
   // ==========================================================
   // Checking and run control
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 8000) begin
         fail_count++;
         tally_and_finish;
      end
   end
   // Loads operands, issues the instruction, waits for its event, checks results
   task automatic op(input logic [31:0] insn, input logic [63:0] src, input logic [63:0] tgt,
      input logic [31:0] cnt, input logic [63:0] exp, input int w, input logic [31:0] st,
      input logic eirq);
      logic [31:0] d;
      logic [1:0] r;
      host.wr(`RMI_ADDR_SRC_LO, src[31:0], r);
      host.wr(`RMI_ADDR_SRC_HI, src[63:32], r);
      host.wr(`RMI_ADDR_TGT_LO, tgt[31:0], r);
      host.wr(`RMI_ADDR_TGT_HI, tgt[63:32], r);
      host.wr(`RMI_ADDR_CNT, cnt, r);
      host.wr(`RMI_ADDR_INSN, insn, r);
      d = 32'h0;
      for (int k = 0; k < 20 && d == 32'h0; k++) host.rd(`RMI_ADDR_IRQ_STAT, d, r);
      chk("irq_stat", {32'h0, st}, {32'h0, d});
      @(negedge aclk);
      chk("irq_level", {63'h0, eirq}, {63'h0, irq});
      host.wr(`RMI_ADDR_IRQ_CLR, 32'h3, r);
      @(negedge aclk);
      chk("irq_after_clear", 64'h0, {63'h0, irq});
      if (st == 32'h1) begin
         if (insn[0]) cond_exp = flg(exp, w);
         host.rd(`RMI_ADDR_RES_LO, d, r);
         chk("result_lo", {32'h0, exp[31:0]}, {32'h0, d});
         host.rd(`RMI_ADDR_RES_HI, d, r);
         chk("result_hi", {32'h0, exp[63:32]}, {32'h0, d});
      end
      host.rd(`RMI_ADDR_STATUS, d, r);
      chk("cond_field", {60'h0, cond_exp}, {60'h0, d[3:0]});
      chk("cond_updated", {63'h0, st == 32'h1 && insn[0]}, {63'h0, d[4]});
      if (st == 32'h2) chk("illegal_flag", 64'h1, {63'h0, d[5]});
      host.rd(`RMI_ADDR_CTRL, d, r);
      chk("exc_reg_kept", {63'h0, so_val}, {63'h0, d[0]});
   endtask
   task automatic dw(input logic [2:0] xo, input int sh, input int m, input logic rc,
      input logic [63:0] src, input logic [63:0] tgt, input logic [31:0] st, input logic eirq);
      logic [63:0] mm;
      logic [63:0] rr;
      logic [63:0] ex;
      rr = rot64(src, sh);
      mm = (xo == `RMI_XO_CLR_RIGHT) ? msk(0, m, 64) : msk(m, 63 - sh, 64);
      ex = (xo == `RMI_XO_CLR_RIGHT) ? (rr & mm) : ((rr & mm) | (tgt & ~mm));
      op({`RMI_OPC_DWORD, 10'h0, sh[4:0], m[5:0], xo, sh[5], rc}, src, tgt, 32'h0, ex, 64,
         st, eirq);
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [63:0] mm;
      logic [31:0] rr;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      host.rd(`RMI_ADDR_STATUS, d, r);
      chk("status_reset", 64'h0, {32'h0, d});
      host.rd(`RMI_ADDR_IRQ_STAT, d, r);
      chk("irq_stat_reset", 64'h0, {32'h0, d});
      host.rd(12'hFFC, d, r);
      chk("unmapped_rresp", {62'h0, `RMI_RESP_SLVERR}, {62'h0, r});
      chk("unmapped_rdata", 64'h0, {32'h0, d});
      host.rd(`RMI_ADDR_IRQ_CLR, d, r);
      chk("clear_reg_rresp", {62'h0, `RMI_RESP_SLVERR}, {62'h0, r});
      host.wr(12'hFFC, 32'hFFFFFFFF, r);
      chk("unmapped_bresp", {62'h0, `RMI_RESP_SLVERR}, {62'h0, r});
      host.wr(`RMI_ADDR_IRQ_EN, 32'h1, r);
      host.wr(`RMI_ADDR_CTRL, 32'h0, r);
      // Word insert: plain, recorded, wrapped, full and zero-result masks
      for (int i = 0; i < 5; i++) begin
         mm = msk(w_mb[i], w_me[i], 32);
         rr = rot32(w_src[i], w_cnt[i][4:0]);
         op({`RMI_OPC_WORD, 15'h0, w_mb[i][4:0], w_me[i][4:0], w_rc[i]}, {32'h0, w_src[i]},
            {HI_KEEP, w_tgt[i]}, w_cnt[i],
            {HI_KEEP, (rr & mm[31:0]) | (w_tgt[i] & ~mm[31:0])},
            32, 32'h1, 1'b1);
      end
      // Doubleword forms with the summary flag raised
      so_val = 1'b1;
      host.wr(`RMI_ADDR_CTRL, 32'h1, r);
      dw(`RMI_XO_CLR_RIGHT, 35, 40, 1'b1, 64'h8123456789ABCDEF, 64'h0, 32'h1,
         1'b1);
      dw(`RMI_XO_INSERT, 10, 7, 1'b0, 64'h0123456789ABCDEF, 64'hFFFF0000FFFF0000, 32'h1,
         1'b1);
      dw(`RMI_XO_INSERT, 0, 0, 1'b1, 64'h0, 64'hFFFFFFFFFFFFFFFF, 32'h1,
         1'b1);
      // Undefined sub-operations: event masked first, then enabled
      dw(3'h2, 4, 4, 1'b1, 64'h1, 64'h2, 32'h2, 1'b0);
      host.wr(`RMI_ADDR_IRQ_EN, 32'h3, r);
      dw(3'h0, 4, 4, 1'b1, 64'h1, 64'h2, 32'h2, 1'b1);
      tally_and_finish;
   end
endmodule // rotate_mask_insert_unit_test
